// ---- verilog/ots_top.sv ----
// Purpose: oscillator trim, select, switch and fail-safe control
// Assumes: Avalon-MM slave with waitrequest, one clock at 50 MHz
// Notes: the switch itself is modelled as a fixed settle delay
//
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: trim value is bits 15:14 high pair and 11:10 low pair
// R2: trim is signed, 0111 fastest, 0000 factory, 1000 slowest
// R3: each trim step is about 1.5 percent of nominal 8 MHz, span 12 percent
// R4: current and new select load from config at reset, others reset zero
// R5: unimplemented bits read zero; lock indicator read only, zero at reset
// R6: software must not switch to a clock below 100 kHz with monitor on
// R7: monitor sees a too slow clock, raises trap, falls back to fast rc
// R8: keys 0x46 then 0x57 then clearing switch request cancels the switch
// R9: oscillator fail trap is hard, level 14, above address error level 13
// R10: protected fields change only right after the two byte unlock
// R11: hardware clears switch request and updates current select on completion
module ots_top #(
  parameter int unsigned FAIL_LIMIT = ots_pkg::FAIL_CYCLES,
  parameter int unsigned SWITCH_DELAY = ots_pkg::SWITCH_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [1:0] cfg_osc_sel_in,
  input wire logic pll_locked_in,
  input wire logic osc_pin_in,
  output logic [3:0] rc_trim_field_out,
  output logic [1:0] current_osc_select_out,
  output logic [1:0] output_divider_select_out,
  output logic low_power_osc_enable_out,
  output logic osc_fail_trap_out,
  output logic [3:0] trap_level_out,
  output logic irq_out
);
  initial begin
    if (SWITCH_DELAY < 1 || SWITCH_DELAY > 255) $error("ots_top: SWITCH_DELAY out of range");
  end
  ots_pkg::ots_ctrl_t ctrl_r, ctrl_nxt;
  logic [1:0] key_r, key_nxt;
  logic [7:0] sw_cnt_r, sw_cnt_nxt;
  logic [2:0] irq_st_r, irq_st_nxt;
  logic [2:0] irq_mk_r, irq_mk_nxt;
  logic mon_en_r, mon_en_nxt;
  logic trap_r, trap_nxt;
  logic irq_r, irq_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wait_r, wait_nxt;
  logic [2:0] lock_sync_r;
  logic lock_r, lock_nxt;
  logic init_r;
  logic [3:0] lvl_r;
  logic mon_fail;

  ots_edge_mon #(
    .LIMIT(FAIL_LIMIT)
  ) u_mon (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .enable_in(mon_en_r),
    .osc_pin_in(osc_pin_in),
    .fail_out(mon_fail)
  );

  function automatic logic [15:0] ctrl_word(input ots_pkg::ots_ctrl_t c, input logic lk);
    logic [15:0] w;
    w = 16'h0000;
    w[ots_pkg::TRIM_HI_POS +: 2] = c.trim[3:2]; // R1
    w[ots_pkg::TRIM_LO_POS +: 2] = c.trim[1:0]; // R1
    w[ots_pkg::CUR_SEL_POS +: 2] = c.cur_sel;
    w[ots_pkg::NEW_SEL_POS +: 2] = c.new_sel;
    w[ots_pkg::DIV_POS +: 2] = c.div;
    w[ots_pkg::LOCK_POS] = lk;
    w[ots_pkg::FAIL_POS] = c.fail;
    w[ots_pkg::LPEN_POS] = c.lp_en;
    w[ots_pkg::SWREQ_POS] = c.sw_req;
    return w; // unimplemented bits stay zero R5
  endfunction

  function automatic logic [15:0] lane_mask(input logic [3:0] be);
    return {{8{be[1]}}, {8{be[0]}}};
  endfunction

  logic wr_go, rd_go;
  assign wr_go = avs_write_in && wait_r;
  assign rd_go = avs_read_in && wait_r;

  always_comb begin
    logic [15:0] cur, wm, nw;
    logic unlocked, byte_wr;
    cur = ctrl_word(ctrl_r, lock_r);
    ctrl_nxt = ctrl_r;
    key_nxt = key_r;
    sw_cnt_nxt = sw_cnt_r;
    irq_st_nxt = irq_st_r;
    irq_mk_nxt = irq_mk_r;
    mon_en_nxt = mon_en_r;
    trap_nxt = 1'b0;
    rdata_nxt = 32'h0000_0000;
    wait_nxt = 1'b1;
    wm = lane_mask(avs_byteenable_in);
    byte_wr = avs_byteenable_in[3:0] == 4'h1;
    unlocked = key_r == 2'h2;
    nw = cur;
    if (wr_go || rd_go) begin
      wait_nxt = 1'b0;
    end
    if (wr_go) begin
      case (avs_address_in)
        ots_pkg::ADDR_OSC_CTRL: begin
          // key sequence is two consecutive byte writes to this register R8
          if (byte_wr && avs_writedata_in[7:0] == ots_pkg::UNLOCK_KEY1) begin
            key_nxt = 2'h1;
          end else if (byte_wr && key_r == 2'h1 &&
                       avs_writedata_in[7:0] == ots_pkg::UNLOCK_KEY2) begin
            key_nxt = 2'h2;
          end else begin
            key_nxt = 2'h0;
            wm = wm & (unlocked ? (ots_pkg::CTRL_WMASK | ots_pkg::PROT_WMASK)
                                : ots_pkg::CTRL_WMASK); // R10
            nw = (cur & ~wm) | (avs_writedata_in[15:0] & wm);
            ctrl_nxt.trim = {nw[ots_pkg::TRIM_HI_POS +: 2], nw[ots_pkg::TRIM_LO_POS +: 2]}; // R1
            ctrl_nxt.new_sel = nw[ots_pkg::NEW_SEL_POS +: 2];
            ctrl_nxt.div = nw[ots_pkg::DIV_POS +: 2];
            ctrl_nxt.lp_en = nw[ots_pkg::LPEN_POS];
            ctrl_nxt.fail = nw[ots_pkg::FAIL_POS];
            ctrl_nxt.sw_req = nw[ots_pkg::SWREQ_POS];
            if (unlocked && ctrl_r.sw_req && !nw[ots_pkg::SWREQ_POS]) begin
              sw_cnt_nxt = 8'h00; // pending switch cancelled R8
              irq_st_nxt[ots_pkg::ST_ABORT] = 1'b1;
            end else if (!ctrl_r.sw_req && nw[ots_pkg::SWREQ_POS]) begin
              sw_cnt_nxt = 8'(SWITCH_DELAY);
            end
          end
        end
        ots_pkg::ADDR_IRQ_STATUS: irq_st_nxt = irq_st_r & ~avs_writedata_in[2:0];
        ots_pkg::ADDR_IRQ_MASK: irq_mk_nxt = avs_writedata_in[2:0];
        ots_pkg::ADDR_MON_CTRL: mon_en_nxt = avs_writedata_in[0];
        default: begin
        end
      endcase
    end else if (rd_go) begin
      case (avs_address_in)
        ots_pkg::ADDR_OSC_CTRL: rdata_nxt = {16'h0000, cur};
        ots_pkg::ADDR_IRQ_STATUS: rdata_nxt = {29'h0, irq_st_r};
        ots_pkg::ADDR_IRQ_MASK: rdata_nxt = {29'h0, irq_mk_r};
        ots_pkg::ADDR_MON_CTRL: rdata_nxt = {31'h0, mon_en_r};
        ots_pkg::ADDR_SEL_CFG: rdata_nxt = {30'h0, cfg_osc_sel_in};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    // switch completion runs after software effects so it wins, except that an abort clearing the request skips it R11
    if (ctrl_r.sw_req && sw_cnt_r != 8'h00 && ctrl_nxt.sw_req) begin
      sw_cnt_nxt = sw_cnt_r - 8'h01;
      if (sw_cnt_r == 8'h01) begin
        ctrl_nxt.sw_req = 1'b0; // R11
        ctrl_nxt.cur_sel = ctrl_r.new_sel; // R11
        irq_st_nxt[ots_pkg::ST_SWDONE] = 1'b1;
      end
    end
    // fail: trap and fall back to fast rc, set beats any clear R7
    if (mon_fail && mon_en_r) begin
      trap_nxt = 1'b1; // R7
      ctrl_nxt.fail = 1'b1;
      ctrl_nxt.cur_sel = ots_pkg::SEL_FAST_RC; // R7
      ctrl_nxt.new_sel = ots_pkg::SEL_FAST_RC;
      ctrl_nxt.sw_req = 1'b0;
      sw_cnt_nxt = 8'h00;
      irq_st_nxt[ots_pkg::ST_FAIL] = 1'b1;
    end
    // lock bit is hardware only R5
    lock_nxt = (lock_sync_r[1] == lock_sync_r[2]) ? lock_sync_r[2] : lock_r;
    irq_nxt = |(irq_st_nxt & irq_mk_nxt);
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_r <= '0; // R4
      key_r <= 2'h0;
      sw_cnt_r <= 8'h00;
      irq_st_r <= ots_pkg::IRQ_RESET;
      irq_mk_r <= ots_pkg::IRQ_RESET;
      mon_en_r <= 1'b0;
      trap_r <= 1'b0;
      irq_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      wait_r <= 1'b1;
      lock_sync_r <= 3'h0;
      lock_r <= 1'b0; // R5
      init_r <= 1'b0;
      lvl_r <= ots_pkg::HARD_TRAP_LEVEL_OSC; // R9
    end else begin
      init_r <= 1'b1;
      lvl_r <= ots_pkg::HARD_TRAP_LEVEL_OSC; // R9
      ctrl_r <= ctrl_nxt;
      if (!init_r) begin
        // config straps caught on the first edge after release R4
        ctrl_r.cur_sel <= cfg_osc_sel_in;
        ctrl_r.new_sel <= cfg_osc_sel_in;
      end
      key_r <= key_nxt;
      sw_cnt_r <= sw_cnt_nxt;
      irq_st_r <= irq_st_nxt;
      irq_mk_r <= irq_mk_nxt;
      mon_en_r <= mon_en_nxt;
      trap_r <= trap_nxt;
      irq_r <= irq_nxt;
      rdata_r <= rdata_nxt;
      wait_r <= wait_nxt;
      lock_sync_r <= {lock_sync_r[1:0], pll_locked_in};
      lock_r <= lock_nxt;
    end
  end

  // trim drives the rc oscillator directly, signed step code R2 R3
  assign rc_trim_field_out = ctrl_r.trim;
  assign current_osc_select_out = ctrl_r.cur_sel;
  assign output_divider_select_out = ctrl_r.div;
  assign low_power_osc_enable_out = ctrl_r.lp_en;
  assign osc_fail_trap_out = trap_r;
  assign trap_level_out = lvl_r; // R9
  assign avs_readdata_out = rdata_r;
  assign avs_waitrequest_out = wait_r;
  assign irq_out = irq_r;

  fail_trap_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // R7
    (mon_fail && mon_en_r) |=> osc_fail_trap_out && current_osc_select_out == 2'h0)
    else $error("fail did not trap to fast rc");
  fail_flag_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // R7
    (mon_fail && mon_en_r) |=> ctrl_r.fail && !ctrl_r.sw_req)
    else $error("fail flag not set or switch left pending");
  // the monitor needs at least two counts between failures, so a trap never merges
  trap_pulse_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // R7
    osc_fail_trap_out |=> !osc_fail_trap_out)
    else $error("trap longer than one cycle");
  trap_prio_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // R9
    osc_fail_trap_out |-> trap_level_out > ots_pkg::HARD_TRAP_LEVEL_ADDR)
    else $error("trap level not above address error");
  // aborts happen only with the key pair standing, so they are kept out here
  switch_done_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // R11
    ($fell(ctrl_r.sw_req) && $past(sw_cnt_r) == 8'h01 && $past(key_r) != 2'h2
     && !$past(mon_fail)) |-> ctrl_r.cur_sel == $past(ctrl_r.new_sel))
    else $error("current select not updated");
  swreq_start_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // R11
    $rose(ctrl_r.sw_req) |-> sw_cnt_r == 8'(SWITCH_DELAY))
    else $error("settle count not loaded");
  prot_field_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // R10
    (init_r && key_r != 2'h2 && !mon_fail) |=> $stable(ctrl_r.new_sel))
    else $error("protected field changed while locked");
  unimpl_zero_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // R5
    (!avs_waitrequest_out && $past(avs_read_in) && $past(avs_address_in) == 4'h0)
    |-> (avs_readdata_out & 32'hFFFF_0014) == 32'h0)
    else $error("unimplemented bits not zero");
  lock_ro_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // R5
    $changed(lock_r) |-> $past(lock_sync_r[1]) == $past(lock_sync_r[2]))
    else $error("lock bit moved without a settled pin");
  trim_map_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // R1
    (!avs_waitrequest_out && $past(avs_read_in) && $past(avs_address_in) == 4'h0)
    |-> {avs_readdata_out[15:14], avs_readdata_out[11:10]} == $past(rc_trim_field_out))
    else $error("trim mapping wrong");
  key_pair_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // R8
    (wr_go && avs_address_in == 4'h0 && avs_byteenable_in == 4'h1 && key_r == 2'h1
     && avs_writedata_in[7:0] == ots_pkg::UNLOCK_KEY2) |=> key_r == 2'h2)
    else $error("key pair not accepted");
  abort_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // R8
    (wr_go && avs_address_in == 4'h0 && key_r == 2'h2 && ctrl_r.sw_req
     && !avs_writedata_in[0] && avs_byteenable_in[0] && avs_writedata_in[7:0] != 8'h46)
    |=> !ctrl_r.sw_req && sw_cnt_r == 8'h00)
    else $error("abort did not cancel");
  reset_sel_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // R4
    (init_r && !$past(init_r)) |-> ctrl_r.cur_sel == $past(cfg_osc_sel_in) && ctrl_r.trim == 4'h0)
    else $error("reset values wrong");
  wait_pulse_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
endmodule
`default_nettype wire

// ---- verilog/ots_pkg.sv ----
// Purpose: constants and carriers for the oscillator tune and switch block
// Assumes: Avalon-MM slave, 32-bit data, word addressed registers
// Notes: control register is 16 bits wide in the low half of its word
package ots_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam logic [3:0] ADDR_OSC_CTRL = 4'h0;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h1;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h2;
  localparam logic [3:0] ADDR_MON_CTRL = 4'h3;
  localparam logic [3:0] ADDR_SEL_CFG = 4'h4;
  // field positions of the control register
  localparam int TRIM_HI_POS = 14;
  localparam int CUR_SEL_POS = 12;
  localparam int TRIM_LO_POS = 10;
  localparam int NEW_SEL_POS = 8;
  localparam int DIV_POS = 6;
  localparam int LOCK_POS = 5;
  localparam int FAIL_POS = 3;
  localparam int LPEN_POS = 1;
  localparam int SWREQ_POS = 0;
  localparam logic [15:0] CTRL_WMASK = 16'hCCCA;
  localparam logic [15:0] PROT_WMASK = 16'h0301;
  localparam logic [7:0] UNLOCK_KEY1 = 8'h46;
  localparam logic [7:0] UNLOCK_KEY2 = 8'h57;
  localparam logic [1:0] SEL_FAST_RC = 2'h0;
  localparam logic [3:0] HARD_TRAP_LEVEL_OSC = 4'hE;
  localparam logic [3:0] HARD_TRAP_LEVEL_ADDR = 4'hD;
  // status bits
  localparam int ST_FAIL = 0;
  localparam int ST_SWDONE = 1;
  localparam int ST_ABORT = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  // fail detection threshold 100 kHz -> longest period 10 us
  localparam int unsigned FAIL_PERIOD_NS = 10000;
  localparam int unsigned FAIL_CYCLES = (FAIL_PERIOD_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int unsigned SWITCH_CYCLES = 16;

  typedef struct packed {
    logic [3:0] trim;
    logic [1:0] cur_sel;
    logic [1:0] new_sel;
    logic [1:0] div;
    logic lp_en;
    logic sw_req;
    logic fail;
  } ots_ctrl_t;
endpackage

// ---- verilog/ots_edge_mon.sv ----
// Purpose: fail-safe monitor, watches a sampled clock pin for edges
// Assumes: pin is asynchronous to ref_clk_in
// Notes: three-stage sync, change counts once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module ots_edge_mon #(
  parameter int unsigned LIMIT = 500
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic osc_pin_in,
  output logic fail_out
);
  initial begin
    if (LIMIT < 2 || LIMIT > 65535) $error("ots_edge_mon: LIMIT out of range");
  end
  logic [2:0] sync_r;
  logic stable_r, stable_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic fail_r, fail_nxt;
  always_comb begin
    stable_nxt = stable_r;
    cnt_nxt = cnt_r;
    fail_nxt = 1'b0;
    if (sync_r[1] == sync_r[2]) begin
      stable_nxt = sync_r[2];
    end
    // restart on a rising level, not a falling one, so the count spans a whole period
    if (!enable_in || (stable_nxt && !stable_r)) begin
      cnt_nxt = 16'h0000;
    end else if (cnt_r >= 16'(LIMIT)) begin
      // a period longer than the threshold counts as a failed clock
      fail_nxt = 1'b1;
      cnt_nxt = 16'h0000;
    end else begin
      cnt_nxt = cnt_r + 16'h0001;
    end
  end
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_r <= 3'h0;
      stable_r <= 1'b0;
      cnt_r <= 16'h0000;
      fail_r <= 1'b0;
    end else begin
      sync_r <= {sync_r[1:0], osc_pin_in};
      stable_r <= stable_nxt;
      cnt_r <= cnt_nxt;
      fail_r <= fail_nxt;
    end
  end
  assign fail_out = fail_r;
endmodule
`default_nettype wire

// ---- tb/tb_ots_top.sv ----
// Purpose: self-checking bench for the oscillator tune and switch block
// Assumes: Avalon-MM master holds each request until it sees waitrequest low
// Notes: a short fail count keeps the run brief, the switch count stays at its default 16
`timescale 1ns/1ps
`default_nettype none
module tb_ots_top;
  localparam int unsigned FL = 20;
  localparam int unsigned SD = 16;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'h0;
  logic [31:0] rdata;
  logic wait_rq;
  logic [1:0] cfg_sel = 2'h2;
  logic locked = 1'b0;
  logic osc_pin = 1'b0;
  logic osc_run = 1'b1;
  logic [1:0] osc_ph = 2'h0;
  logic [3:0] trim;
  logic [1:0] cur_sel;
  logic [1:0] div_sel;
  logic lp_en;
  logic trap;
  logic [3:0] trap_lvl;
  logic irq;
  logic [31:0] v;
  int err_total = 0;
  int n_tests = 0;
  int n_trap = 0;

  ots_top #(.FAIL_LIMIT(FL), .SWITCH_DELAY(SD)) uut (
    .ref_clk_in(clk), .rst_n_in(rst_n), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_rq), .cfg_osc_sel_in(cfg_sel),
    .pll_locked_in(locked), .osc_pin_in(osc_pin), .rc_trim_field_out(trim),
    .current_osc_select_out(cur_sel), .output_divider_select_out(div_sel),
    .low_power_osc_enable_out(lp_en), .osc_fail_trap_out(trap),
    .trap_level_out(trap_lvl), .irq_out(irq)
  );

  always #10 clk = ~clk;
  // eight cycle period: each level must last two samples to pass the sync
  always @(posedge clk) begin
    if (osc_run) osc_ph <= osc_ph + 2'h1;
    if (osc_run && osc_ph == 2'h3) osc_pin <= ~osc_pin;
    if (trap === 1'b1) n_trap <= n_trap + 1;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    @(posedge clk);
    addr <= a;
    rd <= !w;
    wr <= w;
    wdata <= d;
    be <= b;
    // no cycle count assumed: only the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (wait_rq !== 1'b0);
    v = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rdreg(input logic [3:0] a);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask

  task automatic unlock();
    bus(1'b1, ots_pkg::ADDR_OSC_CTRL, 32'h46, 4'h1);
    bus(1'b1, ots_pkg::ADDR_OSC_CTRL, 32'h57, 4'h1);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #60000;
    err_total++;
    conclude();
  end

  initial begin
    logic [3:0] tv [3];
    int n;
    tv = '{4'h7, 4'h0, 4'h8};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rdreg(ots_pkg::ADDR_OSC_CTRL);
    chk("ctrl reset", 32'h2200, v);
    chk("cur sel reset", 32'h2, {30'h0, cur_sel});
    chk("trap level", 32'hE, {28'h0, trap_lvl});
    rdreg(ots_pkg::ADDR_SEL_CFG);
    chk("strap value", 32'h2, v);
    rdreg(4'h9);
    chk("unmapped read", 32'h0, v);
    locked <= 1'b1;
    // protected and read-only bits must survive a plain write of ones
    bus(1'b1, ots_pkg::ADDR_OSC_CTRL, 32'hFFF7, 4'h3);
    rdreg(ots_pkg::ADDR_OSC_CTRL);
    chk("ctrl masked", 32'hEEE2, v);
    chk("trim all ones", 32'hF, {28'h0, trim});
    chk("divider", 32'h3, {30'h0, div_sel});
    chk("low power en", 32'h1, {31'h0, lp_en});
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 4'h0, {16'h0, tv[i][3:2], 2'h0, tv[i][1:0], 10'h0}, 4'h3);
      rdreg(ots_pkg::ADDR_OSC_CTRL);
      chk("trim out", {28'h0, tv[i]}, {28'h0, trim});
      chk("trim bits", {28'h0, tv[i]}, {28'h0, v[15:14], v[11:10]});
    end
    bus(1'b1, ots_pkg::ADDR_OSC_CTRL, 32'h0101, 4'h3);
    rdreg(ots_pkg::ADDR_OSC_CTRL);
    chk("unlocked switch", 32'h2220, v);
    unlock();
    bus(1'b1, ots_pkg::ADDR_OSC_CTRL, 32'h0101, 4'h3);
    n = 0;
    do begin
      rdreg(ots_pkg::ADDR_OSC_CTRL);
      n++;
    end while (v[0] !== 1'b0 && n < 20);
    chk("switch done", 32'h1120, v);
    chk("cur sel switched", 32'h1, {30'h0, cur_sel});
    chk("irq masked", 32'h0, {31'h0, irq});
    rdreg(ots_pkg::ADDR_IRQ_STATUS);
    chk("status done", 32'h2, v);
    bus(1'b1, ots_pkg::ADDR_IRQ_MASK, 32'h2, 4'hF);
    repeat (2) @(posedge clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    bus(1'b1, ots_pkg::ADDR_IRQ_STATUS, 32'h2, 4'hF);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // abort lands while the settle count still runs
    unlock();
    bus(1'b1, ots_pkg::ADDR_OSC_CTRL, 32'h0301, 4'h3);
    unlock();
    bus(1'b1, ots_pkg::ADDR_OSC_CTRL, 32'h0300, 4'h3);
    repeat (SD + 4) @(posedge clk);
    rdreg(ots_pkg::ADDR_OSC_CTRL);
    chk("abort ctrl", 32'h1320, v);
    chk("abort cur sel", 32'h1, {30'h0, cur_sel});
    rdreg(ots_pkg::ADDR_IRQ_STATUS);
    chk("abort status", 32'h4, v);
    // no switch to a slow clock is ever requested while the monitor runs
    bus(1'b1, ots_pkg::ADDR_MON_CTRL, 32'h1, 4'hF);
    repeat (FL * 3) @(posedge clk);
    chk("no trap on live clock", 32'h0, n_trap);
    osc_run <= 1'b0;
    // first trap lands within about FL + 7 cycles, a repeat only FL + 1 later
    repeat (FL + 12) @(posedge clk);
    chk("trap pulses", 32'h1, n_trap);
    chk("cur sel fallback", 32'h0, {30'h0, cur_sel});
    rdreg(ots_pkg::ADDR_OSC_CTRL);
    chk("ctrl after fail", 32'h0028, v);
    rdreg(ots_pkg::ADDR_IRQ_STATUS);
    chk("status fail", 32'h5, v);
    bus(1'b1, ots_pkg::ADDR_IRQ_MASK, 32'h1, 4'hF);
    repeat (2) @(posedge clk);
    chk("irq fail", 32'h1, {31'h0, irq});
    conclude();
  end
endmodule
`default_nettype wire
